// ---- core/cksp_pkg.sv ----
// Package for the system clock select and prescaler block
// Notes on behaviour
// - Divided clock serves CPU, I/O, ADC and flash for every source.
// - Division changes are glitch free, never faster than old or new.
// - Prescaler is a ripple counter on the undivided clock, state hidden.
// - New rate active within T1+T2 to T1+2*T2, two edges between.
// - Clock output enable loads from fuse at reset, software may change it.
// - No clock on output pin during reset; enabled output overrides pin I/O.
// - Output pin carries the divided clock, whatever source is selected.
// - Ready flag bit 7 sets when start-up timeout completes.
// - Trigger bit 6 written with source field switches the clock at once.
// - Source write without trigger only enables oscillator; clock stays put.
// - Start-up bit 4 loads from fuse at reset; with source sets delay.
// - Source bit 3 clear: wake takes 6 CK; reset takes 22 or 20 CK plus 16ms.
// - Ceramic 258 CK, crystal 16K CK, bit 4 ceramic 1K CK; reset adds 16ms.
// - With brown-out detector off, wake is stretched to about 60us.
// - Source codes: 0000 external, 0010 8MHz, 0100 32kHz, 1xxx crystal.
// - Source field loads from fuses at reset, writable, switches glitch free.
// - Source change needs signature then write within four cycles.
// - Prescale register bits 7:4 read as zero.
// - Division code n divides by 2^n up to 8; above 8 reserved. The ripple bit used divides by 2^(n+1).
// - Division change needs the same unlock window.
// - Division resets to 1, or to 8 when divide-by-eight fuse programmed.
package cksp_pkg;
	localparam logic [3:0]  ADR_SETTING     = 4'h0;
	localparam logic [3:0]  ADR_PRESCALE    = 4'h4;
	localparam logic [3:0]  ADR_PROTECT     = 4'h8;
	localparam logic [3:0]  ADR_STATUS      = 4'hc;
	localparam logic [7:0]  UNLOCK_SIG      = 8'hd8;
	localparam int          UNLOCK_CYCLES   = 4;
	localparam int          BIT_READY       = 7;
	localparam int          BIT_TRIGGER     = 6;
	localparam int          BIT_CLOCK_OUT_FUSE       = 5;
	localparam int          BIT_SUT         = 4;
	localparam logic [3:0]  SRC_EXT         = 4'h0;
	localparam logic [3:0]  SRC_RC8M        = 4'h2;
	localparam logic [3:0]  SRC_ULP32K      = 4'h4;
	localparam logic [3:0]  DIV_ONE         = 4'h0;
	localparam logic [3:0]  DIV_EIGHT       = 4'h3;
	localparam logic [3:0]  DIV_MAX         = 4'h8;
	localparam int          CK_WAKE         = 6;
	localparam int          CK_RST_EXT      = 22;
	localparam int          CK_RST_RC       = 20;
	localparam int          CK_CERAMIC      = 258;
	localparam int          CK_CERAMIC_LONG = 1024;
	localparam int          CK_CRYSTAL      = 16384;
	localparam int          CLK_HZ          = 20000000;
	localparam int          RST_EXTRA_MS    = 16;
	localparam int          BOD_WAKE_US     = 60;
	localparam int          RST_EXTRA_CYC   = RST_EXTRA_MS * (CLK_HZ / 1000);
	localparam int          BOD_WAKE_CYC    = BOD_WAKE_US * (CLK_HZ / 1000000);
	typedef struct packed {
		logic       clock_out_fuse;
		logic       startup_time_bit;
		logic [3:0] src;
		logic       div8;
	} cksp_fuse_s;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_READY = 2'b11
	} cksp_osc_e;
endpackage

// ---- core/cksp_top.sv ----
// Clock select, start-up timer and glitch-free prescaler
//
// Implementation choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module cksp_top #(
	parameter int RST_EXTRA = cksp_pkg::RST_EXTRA_CYC,
	parameter int BOD_WAKE  = cksp_pkg::BOD_WAKE_CYC
) (
	// Clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// Fuses and events
	input  wire cksp_pkg::cksp_fuse_s fuse_i,
	input  wire logic               wake_i,
	input  wire logic               bod_off_i,
	input  wire logic               por_start_i,
	// Wishbone slave
	input  wire logic               cyc_i,
	input  wire logic               stb_i,
	input  wire logic               we_i,
	input  wire logic [3:0]         adr_i,
	input  wire logic [3:0]         sel_i,
	input  wire logic [31:0]        dat_i,
	output logic [31:0]             dat_o,
	output logic                    ack_o,
	// Clock outputs
	output logic                    sys_clk_o,
	output logic [3:0]              active_src_o,
	output logic [3:0]              osc_enable_src_o,
	output logic                    run_o,
	output logic                    clock_out_pin_o,
	output logic                    clock_out_oe_o
);
	logic                 clock_out_fuse_reg;
	logic                 sut_reg;
	logic [3:0]           source_select;
	logic [3:0]           active_src_reg;
	logic [3:0]           division_select;
	logic [3:0]           div_act_reg;
	logic [2:0]           unlock_reg;
	logic [8:0]           ripple_reg;
	logic                 sys_clk_reg;
	logic                 pend_reg;
	logic [24:0]          tmo_reg;
	logic                 wake_s1, wake_s2, bod_s1, bod_s2, por_s1, por_s2;
	logic                 wr, rd_req, unlocked, sel0;
	logic [24:0]          delay_next;
	logic [3:0]           div_hi;
	logic [8:0]           div_mask;
	logic                 sys_bit;
	cksp_pkg::cksp_osc_e  osc_reg;

	assign wr       = cyc_i && stb_i && we_i && !ack_o;
	assign rd_req   = cyc_i && stb_i && !ack_o;
	assign sel0     = sel_i[0];
	assign unlocked = unlock_reg != 3'h0;

	// Pin input synchronisers
	always_ff @(posedge clk_i) begin
		wake_s1 <= wake_i;
		wake_s2 <= wake_s1;
		bod_s1  <= bod_off_i;
		bod_s2  <= bod_s1;
		por_s1  <= por_start_i;
		por_s2  <= por_s1;
	end

	// Bus answer, one cycle after request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0;
		end else begin
			ack_o <= rd_req;
			dat_o <= 32'h0;
			if (rd_req) begin
				case (adr_i)
					cksp_pkg::ADR_SETTING: dat_o[7:0] <= {osc_reg == cksp_pkg::ST_READY, 1'b0,
						clock_out_fuse_reg, sut_reg, source_select};
					cksp_pkg::ADR_PRESCALE: dat_o[7:0] <= {4'h0, division_select};
					cksp_pkg::ADR_STATUS: dat_o[7:0] <= {div_act_reg, active_src_reg};
					default: dat_o <= 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			unlock_reg <= 3'h0;
		end else if (wr && sel0 && adr_i == cksp_pkg::ADR_PROTECT && dat_i[7:0] == cksp_pkg::UNLOCK_SIG) begin
			unlock_reg <= 3'(cksp_pkg::UNLOCK_CYCLES);
		end else if (unlocked) begin
			unlock_reg <= unlock_reg - 3'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clock_out_fuse_reg     <= 1'b0;
			sut_reg       <= 1'b0;
			source_select <= cksp_pkg::SRC_RC8M;
			pend_reg      <= 1'b1;
		end else if (pend_reg) begin
			clock_out_fuse_reg     <= fuse_i.clock_out_fuse;
			sut_reg       <= fuse_i.startup_time_bit;
			source_select <= fuse_i.src;
			pend_reg      <= 1'b0;
		end else if (wr && sel0 && adr_i == cksp_pkg::ADR_SETTING) begin
			clock_out_fuse_reg <= dat_i[cksp_pkg::BIT_CLOCK_OUT_FUSE];
			sut_reg   <= dat_i[cksp_pkg::BIT_SUT];
			if (unlocked)
				source_select <= dat_i[3:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			active_src_reg <= cksp_pkg::SRC_RC8M;
		end else if (pend_reg) begin
			active_src_reg <= fuse_i.src;
		end else if (wr && sel0 && unlocked && adr_i == cksp_pkg::ADR_SETTING
			&& dat_i[cksp_pkg::BIT_TRIGGER]) begin
			active_src_reg <= dat_i[3:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			division_select <= cksp_pkg::DIV_ONE;
		end else if (pend_reg) begin
			division_select <= fuse_i.div8 ? cksp_pkg::DIV_EIGHT : cksp_pkg::DIV_ONE;
		end else if (wr && sel0 && unlocked && adr_i == cksp_pkg::ADR_PRESCALE
			&& dat_i[3:0] <= cksp_pkg::DIV_MAX) begin
			division_select <= dat_i[3:0];
		end
	end

	// start-up delay from source and bit
	always_comb begin
		delay_next = 25'(cksp_pkg::CK_WAKE);
		if (source_select[3]) begin
			if (source_select[0])
				delay_next = 25'(cksp_pkg::CK_CRYSTAL);
			else if (sut_reg)
				delay_next = 25'(cksp_pkg::CK_CERAMIC_LONG);
			else
				delay_next = 25'(cksp_pkg::CK_CERAMIC);
		end else if (por_s2) begin
			delay_next = 25'(source_select == cksp_pkg::SRC_RC8M ? cksp_pkg::CK_RST_RC : cksp_pkg::CK_RST_EXT);
		end
		if (por_s2)
			delay_next = delay_next + 25'(RST_EXTRA);
		if (bod_s2 && delay_next < 25'(BOD_WAKE))
			delay_next = 25'(BOD_WAKE);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			osc_reg <= cksp_pkg::ST_IDLE;
			tmo_reg <= 25'h0;
		end else begin
			case (osc_reg)
				cksp_pkg::ST_IDLE: begin
					osc_reg <= cksp_pkg::ST_WAIT;
					tmo_reg <= delay_next;
				end
				cksp_pkg::ST_WAIT: begin
					if (tmo_reg <= 25'h1)
						osc_reg <= cksp_pkg::ST_READY;
					tmo_reg <= tmo_reg - 25'h1;
				end
				cksp_pkg::ST_READY: begin
					if (wake_s2 || (wr && sel0 && unlocked && adr_i == cksp_pkg::ADR_SETTING))
						osc_reg <= cksp_pkg::ST_IDLE;
				end
				default: osc_reg <= cksp_pkg::ST_IDLE;
			endcase
		end
	end

	// free running count on undivided clock
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ripple_reg <= 9'h0;
		else
			ripple_reg <= ripple_reg + 9'h1;
	end

	// widest bit of old and new sets the switch boundary
	always_comb begin
		div_hi = div_act_reg;
		if (division_select > div_act_reg)
			div_hi = division_select;
		div_mask = 9'((10'h2 << div_hi) - 10'h1);
		sys_bit  = ripple_reg[div_act_reg];
	end

	// switch where old and new bits fall together
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_act_reg <= cksp_pkg::DIV_ONE;
		end else if (div_act_reg != division_select && (ripple_reg & div_mask) == div_mask) begin
			div_act_reg <= division_select;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			sys_clk_reg <= 1'b0;
		else
			sys_clk_reg <= sys_bit;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clock_out_pin_o <= 1'b0;
			clock_out_oe_o  <= 1'b0;
		end else begin
			clock_out_pin_o <= sys_clk_reg & clock_out_fuse_reg;
			clock_out_oe_o  <= clock_out_fuse_reg;
		end
	end

	// Registered outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sys_clk_o        <= 1'b0;
			active_src_o     <= cksp_pkg::SRC_RC8M;
			osc_enable_src_o <= cksp_pkg::SRC_RC8M;
			run_o            <= 1'b0;
		end else begin
			sys_clk_o        <= sys_clk_reg;
			active_src_o     <= active_src_reg;
			osc_enable_src_o <= source_select;
			run_o            <= osc_reg == cksp_pkg::ST_READY;
		end
	end

	sequence unlock_seq;
		wr && sel0 && adr_i == cksp_pkg::ADR_PROTECT && dat_i[7:0] == cksp_pkg::UNLOCK_SIG;
	endsequence
	window_open_a: assert property (@(posedge clk_i) disable iff (rst_i) unlock_seq |=> unlock_reg == 3'd4)
		else $error("unlock window not opened");
	locked_src_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!pend_reg && !unlocked |=> $stable(source_select))
		else $error("source changed while locked");
	locked_div_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!pend_reg && !unlocked |=> $stable(division_select))
		else $error("division changed while locked");
	div_range_a: assert property (@(posedge clk_i) disable iff (rst_i) division_select <= 4'h8)
		else $error("reserved division code");
	pin_reset_a: assert property (@(posedge clk_i) $past(rst_i) |-> !clock_out_oe_o && !clock_out_pin_o)
		else $error("clock output during reset");
	pin_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> clock_out_oe_o == $past(clock_out_fuse_reg))
		else $error("output enable not following bit");
	trig_switch_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!pend_reg && wr && sel0 && unlocked && adr_i == 4'h0 && dat_i[6] |=> active_src_reg == $past(dat_i[3:0]))
		else $error("trigger did not switch");
	no_trig_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!pend_reg && wr && adr_i == 4'h0 && !dat_i[6] |=> $stable(active_src_reg))
		else $error("switched without trigger");
	ready_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
		osc_reg == cksp_pkg::ST_WAIT && tmo_reg == 25'h1 |=> osc_reg == cksp_pkg::ST_READY)
		else $error("ready not set after time-out");
	reserved_rd_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_req && adr_i == 4'h4 |=> dat_o[7:4] == 4'h0)
		else $error("reserved bits nonzero");

	sequence src_write_seq;
		wr && sel0 && unlocked && adr_i == cksp_pkg::ADR_SETTING;
	endsequence
	sequence div_write_seq;
		wr && sel0 && unlocked && adr_i == cksp_pkg::ADR_PRESCALE && dat_i[3:0] <= cksp_pkg::DIV_MAX;
	endsequence

	src_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!pend_reg ##0 src_write_seq |=> source_select == $past(dat_i[3:0]))
		else $error("source write not taken");

	div_take_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!pend_reg ##0 div_write_seq |=> division_select == $past(dat_i[3:0]))
		else $error("division write not taken");

	div_reserved_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!pend_reg && wr && adr_i == cksp_pkg::ADR_PRESCALE && dat_i[3:0] > cksp_pkg::DIV_MAX
		|=> $stable(division_select))
		else $error("reserved division code taken");

	ripple_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> ripple_reg == 9'($past(ripple_reg) + 9'h1))
		else $error("ripple count skipped");

	sys_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> sys_clk_reg == $past(sys_bit))
		else $error("system clock not from selected bit");

	div_switch_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$changed(div_act_reg) |-> sys_clk_reg ##1 !sys_clk_reg)
		else $error("division switched off a falling boundary");

	pend_switch_a: assert property (@(posedge clk_i) disable iff (rst_i)
		div_act_reg != division_select |-> ##[1:600] div_act_reg == division_select)
		else $error("new division never took effect");

	pin_copy_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> clock_out_pin_o == $past(sys_clk_reg && clock_out_fuse_reg))
		else $error("output pin not the divided clock");

	sys_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> sys_clk_o == $past(sys_clk_reg))
		else $error("system clock output stale");

	run_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> run_o == $past(osc_reg == cksp_pkg::ST_READY))
		else $error("run output not the ready flag");

	timer_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
		osc_reg == cksp_pkg::ST_IDLE |=> osc_reg == cksp_pkg::ST_WAIT && tmo_reg == $past(delay_next))
		else $error("start-up timer not loaded");

	delay_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!source_select[3] && !por_s2 && !bod_s2 |-> delay_next == 25'(cksp_pkg::CK_WAKE))
		else $error("wake delay wrong");

	delay_por_a: assert property (@(posedge clk_i) disable iff (rst_i)
		source_select == cksp_pkg::SRC_RC8M && por_s2 && !bod_s2
		|-> delay_next == 25'(cksp_pkg::CK_RST_RC) + 25'(RST_EXTRA))
		else $error("reset delay wrong");

	delay_xtal_a: assert property (@(posedge clk_i) disable iff (rst_i)
		source_select[3] && source_select[0] |-> delay_next >= 25'(cksp_pkg::CK_CRYSTAL))
		else $error("crystal delay short");

	delay_cer_a: assert property (@(posedge clk_i) disable iff (rst_i)
		source_select[3] && !source_select[0] && sut_reg |-> delay_next >= 25'(cksp_pkg::CK_CERAMIC_LONG))
		else $error("long ceramic delay short");

	delay_short_a: assert property (@(posedge clk_i) disable iff (rst_i)
		source_select[3] && !source_select[0] && !sut_reg && !por_s2 && !bod_s2
		|-> delay_next == 25'(cksp_pkg::CK_CERAMIC))
		else $error("ceramic delay wrong");

	delay_bod_a: assert property (@(posedge clk_i) disable iff (rst_i)
		bod_s2 |-> delay_next >= 25'(BOD_WAKE))
		else $error("brown-out wake delay short");

	bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |=> !ack_o)
		else $error("ack held two cycles");

	bus_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("request not answered");

	trig_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		rd_req && adr_i == cksp_pkg::ADR_SETTING |=> dat_o[6] == 1'b0)
		else $error("trigger bit read nonzero");

	locked_trig_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!pend_reg && !unlocked |=> $stable(active_src_reg))
		else $error("active source changed while locked");

	clock_out_fuse_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!pend_reg && wr && sel0 && adr_i == cksp_pkg::ADR_SETTING
		|=> clock_out_fuse_reg == $past(dat_i[cksp_pkg::BIT_CLOCK_OUT_FUSE]))
		else $error("output enable write lost");

	sut_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!pend_reg && wr && sel0 && adr_i == cksp_pkg::ADR_SETTING
		|=> sut_reg == $past(dat_i[cksp_pkg::BIT_SUT]))
		else $error("start-up bit write lost");

	fuse_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
		pend_reg |=> source_select == $past(fuse_i.src) && sut_reg == $past(fuse_i.startup_time_bit))
		else $error("fuses not loaded");

	div_fuse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		pend_reg |=> division_select == ($past(fuse_i.div8) ? cksp_pkg::DIV_EIGHT : cksp_pkg::DIV_ONE))
		else $error("division fuse not loaded");
endmodule
`default_nettype wire

// ---- testbench/test_system_clock_select_prescaler.sv ----
// Bench for the clock select and prescaler block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
	$display("Error at %0t: got %h expected %h", $time, a, e); end end
module test_system_clock_select_prescaler;
	logic                 clk_i = 1'b0;
	logic                 rst_i = 1'b1;
	cksp_pkg::cksp_fuse_s fuse  = '{1'b1, 1'b0, cksp_pkg::SRC_RC8M, 1'b1};
	logic                 cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [3:0]           adr = 4'h0, sel = 4'h0;
	logic [31:0]          wdat = 32'h0, rdat;
	logic                 ack, sclk, run, pin, oe;
	logic                 wake = 1'b0, por = 1'b0, brownout_detector = 1'b0;
	logic [3:0]           act_src, osc_en;
	logic [7:0]           q;
	int                   failures = 0, checks_done = 0, p, p0, k;
	logic [3:0]           srcs [3] = '{cksp_pkg::SRC_EXT, cksp_pkg::SRC_RC8M, cksp_pkg::SRC_ULP32K};
	always #25 clk_i = ~clk_i;
	cksp_top #(.RST_EXTRA(20), .BOD_WAKE(8)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .fuse_i(fuse), .wake_i(wake), .bod_off_i(brownout_detector),
		.por_start_i(por), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
		.dat_i(wdat), .dat_o(rdat), .ack_o(ack), .sys_clk_o(sclk), .active_src_o(act_src),
		.osc_enable_src_o(osc_en), .run_o(run), .clock_out_pin_o(pin), .clock_out_oe_o(oe));
	// One classic bus cycle, ack and data taken at the edge that samples ack high
	task automatic wb(input logic [3:0] a, input logic w, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'h1; wdat <= {24'h0, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (ack !== 1'b1)
			failures++;
		q = rdat[7:0];
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	endtask
	task automatic prot(input logic [3:0] a, input logic [7:0] d);
		wb(cksp_pkg::ADR_PROTECT, 1'b1, cksp_pkg::UNLOCK_SIG);
		wb(a, 1'b1, d);
	endtask
	// Clock cycles between two rising edges of the output pin
	task automatic period(output int r);
		logic prv;
		int n, c;
		r = 0; n = 0; c = 0; prv = pin;
		while (c < 2 && n < 3000) begin
			@(negedge clk_i);
			n++;
			if (c > 0) r++;
			if (!prv && pin === 1'b1) c++;
			prv = pin;
		end
	endtask
	task automatic do_reset();
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		`CHK(oe, 1'b0)
		@(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask
	task automatic results();
		$display("Checks %0d, failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		#(50 * 60000);
		failures++;
		results();
	end
	initial begin
		do_reset();
		wb(cksp_pkg::ADR_SETTING, 1'b0, 8'h0);
		`CHK(q & 8'h7f, 8'h22)
		wb(cksp_pkg::ADR_PRESCALE, 1'b0, 8'h0);
		`CHK(q, {4'h0, cksp_pkg::DIV_EIGHT})
		k = 0;
		do begin
			wb(cksp_pkg::ADR_SETTING, 1'b0, 8'h0);
			k++;
		end while (q[7] !== 1'b1 && k < 100);
		`CHK(q[7], 1'b1)
		`CHK(run, 1'b1)
		wb(cksp_pkg::ADR_PRESCALE, 1'b1, 8'h01);
		wb(cksp_pkg::ADR_PRESCALE, 1'b0, 8'h0);
		`CHK(q, 8'h03)
		prot(cksp_pkg::ADR_PRESCALE, 8'h09);
		wb(cksp_pkg::ADR_PRESCALE, 1'b0, 8'h0);
		`CHK(q, 8'h03)
		// Every division code, pin period scales by a power of two
		for (int n = 0; n <= 8; n++) begin
			prot(cksp_pkg::ADR_PRESCALE, 8'(n));
			wb(cksp_pkg::ADR_PRESCALE, 1'b0, 8'h0);
			`CHK(q, 8'(n))
			period(p);
			period(p);
			period(p);
			if (n == 0) p0 = p;
			`CHK(p, p0 << n)
			`CHK(p0 > 1, 1'b1)
			wb(cksp_pkg::ADR_STATUS, 1'b0, 8'h0);
			`CHK(q[7:4], 4'(n))
			`CHK(oe, 1'b1)
		end
		wb(cksp_pkg::ADR_SETTING, 1'b1, 8'h02);
		wb(cksp_pkg::ADR_SETTING, 1'b0, 8'h0);
		`CHK(oe, 1'b0)
		wb(cksp_pkg::ADR_SETTING, 1'b1, 8'h62);
		wb(cksp_pkg::ADR_SETTING, 1'b1, 8'h60);
		wb(cksp_pkg::ADR_SETTING, 1'b0, 8'h0);
		`CHK(act_src, cksp_pkg::SRC_RC8M)
		prot(cksp_pkg::ADR_SETTING, 8'h24);
		wb(cksp_pkg::ADR_SETTING, 1'b0, 8'h0);
		`CHK(osc_en, cksp_pkg::SRC_ULP32K)
		`CHK(act_src, cksp_pkg::SRC_RC8M)
		for (int i = 0; i < 3; i++) begin
			prot(cksp_pkg::ADR_SETTING, 8'h60 | 8'(srcs[i]));
			wb(cksp_pkg::ADR_SETTING, 1'b0, 8'h0);
			`CHK(act_src, srcs[i])
			`CHK(q[6:0], 7'h20 | 7'(srcs[i]))
		end
		fuse <= '{1'b0, 1'b1, cksp_pkg::SRC_ULP32K, 1'b0};
		por <= 1'b1;
		brownout_detector <= 1'b1;
		do_reset();
		wb(cksp_pkg::ADR_SETTING, 1'b0, 8'h0);
		`CHK(q & 8'h7f, 8'h14)
		`CHK(q[7], 1'b0)
		wb(cksp_pkg::ADR_PRESCALE, 1'b0, 8'h0);
		`CHK(q, {4'h0, cksp_pkg::DIV_ONE})
		`CHK(oe, 1'b0)
		k = 0;
		do begin
			wb(cksp_pkg::ADR_SETTING, 1'b0, 8'h0);
			k++;
		end while (q[7] !== 1'b1 && k < 100);
		`CHK(k > 5, 1'b1)
		`CHK(q[7], 1'b1)
		results();
	end
endmodule
`default_nettype wire
